// *** hdl/opd_term_ctrl.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "opd_cfg.svh"
module opd_term_ctrl
  import opd_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        odt_pin,
  input  wire logic        cke_pin,
  input  wire logic        refresh_cmd,
  output logic             term_on,
  output logic             term_async
);

  // Asynchronous response delay in clocks: the smaller of the two bound counts, at least 1 clock
  localparam int ASYNC_CYC = (`OPD_ASYNC_MIN_CYC < `OPD_ASYNC_MAX_CYC) ?
                             `OPD_ASYNC_MIN_CYC : `OPD_ASYNC_MAX_CYC;
  localparam logic [4:0] ASYNC_TAP = 5'(ASYNC_CYC - 1);

  opd_ctrl_t   ctrl;
  opd_timing_t timing;
  opd_pins_t   pin_meta;
  opd_pins_t   pin_s;
  logic        cke_q;
  opd_state_t  state;
  logic [7:0]  win_cnt;
  logic [7:0]  rfc_cnt;
  logic [7:0]  next_win_cnt;
  opd_state_t  next_state;
  logic        sync_term;
  logic        async_term;
  logic [4:0]  sync_tap;
  logic [5:0]  wl;
  logic [5:0]  lead;
  logic        term_enabled;
  logic        dll_off_pd;
  logic        use_async;
  logic        cke_fall;
  logic        cke_rise;
  logic        acc;
  logic        hit_ctrl;
  logic        hit_timing;
  logic        hit_status;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
    addr_is = (a[11:2] == ofs[11:2]);
  endfunction : addr_is

  // Pin synchronisers: the first stage feeds only the second
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pin_meta <= '0;
      pin_s    <= '0;
    end else if (clk_en) begin
      pin_meta <= '{ref_cmd: refresh_cmd, cke: cke_pin, odt: odt_pin};
      pin_s    <= pin_meta;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cke_q <= 1'b0;
    end else if (clk_en) begin
      cke_q <= pin_s.cke;
    end
  end

  assign cke_fall = cke_q & ~pin_s.cke;
  assign cke_rise = ~cke_q & pin_s.cke;

  // Latency arithmetic
  always_comb begin
    wl       = 6'(timing.cwl) + 6'(timing.al);
    lead     = (wl > 6'h01) ? wl - 6'h01 : 6'h01;
    // Both latencies are WL - 2; the line's tap n already gives n+1 clocks
    sync_tap = (wl > 6'h03) ? 5'(wl - 6'h03) : 5'h00;
  end

  assign term_enabled = ctrl.nom_term_en | ctrl.wr_term_en;
  // Transitions exist only with DLL off in precharge power-down
  assign dll_off_pd   = ~ctrl.dll_on_ppd & ctrl.dll_on_mode & term_enabled;

  // Synchronous path carries additive latency inside the tap
  opd_delay_line u_sync_line (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .din     (pin_s.odt),
    .tap     (sync_tap),
    .dout    (sync_term)
  );

  // Asynchronous path: fixed analog-style delay, no additive latency
  opd_delay_line u_async_line (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .clk_en  (clk_en),
    .din     (pin_s.odt),
    .tap     (ASYNC_TAP),
    .dout    (async_term)
  );

  // Refresh cycle timer; a new REFRESH restarts it
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rfc_cnt <= 8'h00;
    end else if (clk_en) begin
      if (pin_s.ref_cmd) begin
        rfc_cnt <= timing.rfc;
      end else if (rfc_cnt != 8'h00) begin
        rfc_cnt <= rfc_cnt - 8'h01;
      end
    end
  end

  // Power-down transition tracker. Entry stays synchronous until it ends;
  // power-down and exit stay asynchronous until the DLL-exit time elapses.
  // Either choice lies inside what the windows permit.
  always_comb begin
    next_state   = state;
    next_win_cnt = win_cnt;
    case (state)
      OPD_ACTIVE: begin
        if (cke_fall && dll_off_pd) begin
          if (rfc_cnt > 8'h01) begin
            next_state   = OPD_ENTRY;
            next_win_cnt = rfc_cnt - 8'h01;
          end else begin
            next_state   = OPD_PDOWN;
          end
        end
      end
      OPD_ENTRY: begin
        if (cke_rise) begin
          // Short low pulse: stay mixed through the end of exit
          next_state   = OPD_EXIT;
          next_win_cnt = timing.xpdll;
        end else if (win_cnt <= 8'h01) begin
          next_state   = OPD_PDOWN;
          next_win_cnt = 8'h00;
        end else begin
          next_win_cnt = win_cnt - 8'h01;
        end
      end
      OPD_PDOWN: begin
        if (cke_rise) begin
          next_state   = OPD_EXIT;
          next_win_cnt = timing.xpdll;
        end
      end
      OPD_EXIT: begin
        if (cke_fall && dll_off_pd) begin
          // Short high pulse: exit runs straight into power-down, skipping entry
          next_state   = OPD_PDOWN;
          next_win_cnt = 8'h00;
        end else if (win_cnt <= 8'h01) begin
          next_state   = OPD_ACTIVE;
          next_win_cnt = 8'h00;
        end else begin
          next_win_cnt = win_cnt - 8'h01;
        end
      end
      default: begin
        next_state   = OPD_ACTIVE;
        next_win_cnt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state   <= OPD_ACTIVE;
      win_cnt <= 8'h00;
    end else if (clk_en) begin
      if (!dll_off_pd && state != OPD_EXIT) begin
        // DLL kept on in power-down: pure synchronous operation
        state   <= OPD_ACTIVE;
        win_cnt <= 8'h00;
      end else begin
        state   <= next_state;
        win_cnt <= next_win_cnt;
      end
    end
  end

  always_comb begin
    use_async = (dll_off_pd && (state == OPD_PDOWN || state == OPD_EXIT))
              || (ctrl.relock && term_enabled);
  end

  // Termination output: async uses the short path, sync the latency path.
  // Entry and exit choose one response; pending sync edges may be dropped.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      term_on    <= 1'b0;
      term_async <= 1'b0;
    end else if (clk_en) begin
      term_async <= use_async;
      if (!term_enabled) begin
        term_on <= 1'b0;
      end else if (use_async) begin
        term_on <= async_term;
      end else begin
        term_on <= sync_term;
      end
    end
  end

  // APB slave: answers one cycle into the access phase
  assign acc        = psel & penable & ~pready;
  assign hit_ctrl   = addr_is(paddr, `OPD_OFS_CTRL);
  assign hit_timing = addr_is(paddr, `OPD_OFS_TIMING);
  assign hit_status = addr_is(paddr, `OPD_OFS_STATUS);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl   <= opd_ctrl_t'(5'(`OPD_CTRL_RST));
      timing <= opd_timing_t'(26'(`OPD_TIM_RST));
    end else if (clk_en && psel && penable && pready && pwrite) begin
      // Commit only at the edge where the master samples pready high
      if (hit_ctrl) begin
        ctrl <= opd_ctrl_t'(pwdata[4:0]);
      end
      if (hit_timing) begin
        timing <= opd_timing_t'(pwdata[25:0]);
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= acc;
      pslverr <= acc & ~(hit_ctrl | hit_timing | hit_status);
      prdata  <= 32'h0000_0000;
      if (acc && !pwrite) begin
        if (hit_ctrl) begin
          prdata <= {27'h0, ctrl};
        end else if (hit_timing) begin
          prdata <= {6'h00, timing};
        end else if (hit_status) begin
          prdata[`OPD_STA_TERM]  <= term_on;
          prdata[`OPD_STA_ASYNC] <= term_async;
          prdata[`OPD_STA_ENTRY] <= (state == OPD_ENTRY);
          prdata[`OPD_STA_EXIT]  <= (state == OPD_EXIT);
          prdata[`OPD_STA_PDOWN] <= (state == OPD_PDOWN);
          prdata[`OPD_STA_LEAD_LSB +: 6] <= lead;
        end
      end
    end
  end

endmodule : opd_term_ctrl
`default_nettype wire

// *** hdl/opd_cfg.svh ***
`ifndef OPD_CFG_SVH
`define OPD_CFG_SVH

`define OPD_OFS_CTRL        12'h000
`define OPD_OFS_TIMING      12'h004
`define OPD_OFS_STATUS      12'h008

`define OPD_CTRL_DLL_PPD    0
`define OPD_CTRL_NOM_TERM   1
`define OPD_CTRL_WR_TERM    2
`define OPD_CTRL_DLL_ON     3
`define OPD_CTRL_RELOCK     4
`define OPD_CTRL_RST        32'h0000_0008

`define OPD_TIM_CWL_LSB     0
`define OPD_TIM_AL_LSB      5
`define OPD_TIM_RFC_LSB     10
`define OPD_TIM_XPDLL_LSB   18
`define OPD_TIM_RST         32'h0280_4005

`define OPD_STA_TERM        0
`define OPD_STA_ASYNC       1
`define OPD_STA_ENTRY       2
`define OPD_STA_EXIT        3
`define OPD_STA_PDOWN       4
`define OPD_STA_LEAD_LSB    8

`define OPD_CLK_PS          10000
`define OPD_ASYNC_MIN_PS    2000
`define OPD_ASYNC_MAX_PS    8500
`define OPD_ASYNC_MIN_CYC   ((`OPD_ASYNC_MIN_PS + `OPD_CLK_PS - 1) / `OPD_CLK_PS)
`define OPD_ASYNC_MAX_RAW   (`OPD_ASYNC_MAX_PS / `OPD_CLK_PS)
`define OPD_ASYNC_MAX_CYC   ((`OPD_ASYNC_MAX_RAW < 1) ? 1 : `OPD_ASYNC_MAX_RAW)

`endif

// *** hdl/opd_pkg.sv ***
package opd_pkg;

  typedef enum logic [1:0] {
    OPD_ACTIVE = 2'b00,
    OPD_ENTRY  = 2'b01,
    OPD_PDOWN  = 2'b11,
    OPD_EXIT   = 2'b10
  } opd_state_t;

  typedef struct packed {
    logic relock;
    logic dll_on_mode;
    logic wr_term_en;
    logic nom_term_en;
    logic dll_on_ppd;
  } opd_ctrl_t;

  typedef struct packed {
    logic [7:0] xpdll;
    logic [7:0] rfc;
    logic [4:0] al;
    logic [4:0] cwl;
  } opd_timing_t;

  typedef struct packed {
    logic ref_cmd;
    logic cke;
    logic odt;
  } opd_pins_t;

endpackage : opd_pkg

// *** hdl/opd_delay_line.sv ***
`timescale 1ns/1ns
`default_nettype none
module opd_delay_line
  import opd_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       din,
  input  wire logic [4:0] tap,
  output logic            dout
);
  logic [31:0] line;

  // Stage 0 is one clock of delay; tap n gives n+1 clocks
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      line <= 32'h0000_0000;
    end else if (clk_en) begin
      line <= {line[30:0], din};
    end
  end

  always_comb begin
    dout = line[tap];
  end
endmodule : opd_delay_line
`default_nettype wire

// *** testbench/opd_term_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module opd_term_checker (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        odt_pin,
  input wire logic        cke_pin,
  input wire logic        refresh_cmd,
  input wire logic        term_on,
  input wire logic        term_async
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_apb_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("access phase not two cycles");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("bus outputs not quiet");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr[11:2] > 10'h002))
    else $error("pslverr wrong for address");
  a_async_follow: assert property (term_async [*6] |-> term_on == $past(odt_pin, 4))
    else $error("async termination lag wrong");
  a_sync_follow: assert property (!term_async [*8] |-> term_on == $past(odt_pin, 6))
    else $error("sync termination lag wrong");
  a_rise_cause: assert property ($rose(term_on) |-> $past(odt_pin, 4) || $past(odt_pin, 6))
    else $error("termination rose without odt");
  a_fall_cause: assert property ($fell(term_on) |-> !$past(odt_pin, 4) || !$past(odt_pin, 6))
    else $error("termination fell without odt");
endmodule : opd_term_checker

bind opd_term_ctrl opd_term_checker u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .odt_pin(odt_pin),
  .cke_pin(cke_pin), .refresh_cmd(refresh_cmd), .term_on(term_on),
  .term_async(term_async)
);
`default_nettype wire

// *** testbench/opd_ddr_ctrl_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module opd_ddr_ctrl_model (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic odt_req,
  input  wire logic cke_req,
  input  wire logic ref_req,
  output logic      odt_pin,
  output logic      cke_pin,
  output logic      refresh_cmd
);
  logic ref_q;
  // Pins launch from a register like a real PHY; ODT moves only when asked,
  // so the bench keeps it still across windows of uncertain termination
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      odt_pin <= 1'b0;
      cke_pin <= 1'b1;
      ref_q <= 1'b0;
      refresh_cmd <= 1'b0;
    end else begin
      odt_pin <= odt_req;
      cke_pin <= cke_req;
      ref_q <= ref_req;
      refresh_cmd <= ref_req && !ref_q;
    end
  end
endmodule : opd_ddr_ctrl_model
`default_nettype wire

// *** testbench/test_odt_power_down_transition.sv ***
`timescale 1ns/1ns
`default_nettype none
module test_odt_power_down_transition;
  import opd_pkg::*;
  localparam int ASYNC_LAT = 5; // Includes the pin model register
  localparam int SYNC_LAT  = 7;
  localparam int XPDLL     = 10;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        odt_req, cke_req, ref_req, odt_pin, cke_pin, refresh_cmd;
  logic        term_on, term_async;
  int          error_cnt, n_checks, n;

  opd_term_ctrl DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .odt_pin(odt_pin),
    .cke_pin(cke_pin), .refresh_cmd(refresh_cmd), .term_on(term_on),
    .term_async(term_async));
  opd_ddr_ctrl_model u_mdl (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .odt_req(odt_req), .cke_req(cke_req),
    .ref_req(ref_req), .odt_pin(odt_pin), .cke_pin(cke_pin),
    .refresh_cmd(refresh_cmd));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Cycles from the ODT request until termination shows the new level
  task automatic lat(input logic v);
    @(posedge clk_sys);
    odt_req <= v;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (term_on !== v && n < 20);
  endtask : lat

  task automatic wait_async(input logic v);
    n = 0;
    while (term_async !== v && n < 40) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask : wait_async

  task automatic set_cke(input logic v);
    @(posedge clk_sys);
    cke_req <= v;
  endtask : set_cke

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    #100000;
    error_cnt++;
    summarize();
  end

  initial begin
    {sys_rst, cke_req} = 2'b11;
    {psel, penable, pwrite, odt_req, ref_req} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctrl reset", rd, 32'h0000_0008);
    apb(1'b0, 12'h004, 32'h0);
    chk("timing reset", rd, 32'h0280_4005);
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    // Same write latency as reset but nonzero additive latency
    apb(1'b1, 12'h004, 32'h0028_4043);
    apb(1'b0, 12'h008, 32'h0);
    chk("lead", {26'h0, rd[13:8]}, 32'h4);
    $display("test registers done");
    apb(1'b1, 12'h000, 32'h0000_000A);
    lat(1'b1);
    chk("sync on", n, SYNC_LAT);
    lat(1'b0);
    chk("sync off", n, SYNC_LAT);
    $display("test sync done");
    set_cke(1'b0);
    wait_async(1'b1);
    chk("pd async", term_async, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk("pd status", rd[4:0], 5'h12);
    lat(1'b1);
    chk("async on", n, ASYNC_LAT);
    lat(1'b0);
    chk("async off", n, ASYNC_LAT);
    set_cke(1'b1);
    wait_async(1'b0);
    chk("exit len", n >= XPDLL && n <= XPDLL + 6, 1);
    $display("test power down done");
    // Refresh goes out first so its timer runs when CKE is seen low
    @(posedge clk_sys);
    ref_req <= 1'b1;
    set_cke(1'b0);
    repeat (5) @(posedge clk_sys);
    apb(1'b0, 12'h008, 32'h0);
    chk("entry stretch", rd[2:1], 2'b10);
    ref_req <= 1'b0;
    wait_async(1'b1);
    chk("stretch len", n > 5 && n < 40, 1);
    set_cke(1'b1);
    wait_async(1'b0);
    $display("test refresh done");
    apb(1'b1, 12'h000, 32'h0000_000B);
    set_cke(1'b0);
    wait_async(1'b1);
    chk("dll kept on", term_async, 1'b0);
    set_cke(1'b1);
    apb(1'b1, 12'h000, 32'h0000_001C);
    wait_async(1'b1);
    chk("relock async", term_async, 1'b1);
    $display("test modes done");
    summarize();
  end
endmodule : test_odt_power_down_transition
`default_nettype wire
